// *** common/dspt_pkg.sv ***
// Package of constants, bus carriers and state layout for the dual-slope PWM timer with asynchronous clocking.
package dspt_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [31:0] OFS_CONTROL = 32'h0000_0000;
  localparam logic [31:0] OFS_COUNT = 32'h0000_0004;
  localparam logic [31:0] OFS_COMPARE = 32'h0000_0008;
  localparam logic [31:0] OFS_STATUS = 32'h0000_000c;
  localparam logic [31:0] OFS_FLAGS = 32'h0000_0010;
  localparam logic [31:0] OFS_ENABLE = 32'h0000_0014;

  // Control register field positions.
  localparam int CTL_WGM_LO = 6;
  localparam int CTL_COM_HI = 5;
  localparam int CTL_COM_LO = 4;
  localparam int CTL_WGM_HI = 3;
  localparam logic [7:0] CTL_WRITE_MASK = 8'h7f;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // Status register field positions; the busy bits are count at bit 2, compare at bit 1 and control at bit 0.
  localparam int STS_ASYNC = 3;
  localparam int BUSY_COUNT = 2;
  localparam int BUSY_COMPARE = 1;
  localparam int BUSY_CONTROL = 0;

  // Flag and enable register field positions.
  localparam int FLG_OVERFLOW = 0;
  localparam int FLG_COMPARE = 1;

  // Waveform mode codes.
  localparam logic [1:0] MODE_DUAL_SLOPE = 2'h1;

  // Counter limits.
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;

  // Prescaler masks: a tick is issued when all masked bits are ones.
  localparam logic [9:0] PSC_DIV1 = 10'h000;
  localparam logic [9:0] PSC_DIV8 = 10'h007;
  localparam logic [9:0] PSC_DIV32 = 10'h01f;
  localparam logic [9:0] PSC_DIV64 = 10'h03f;
  localparam logic [9:0] PSC_DIV128 = 10'h07f;
  localparam logic [9:0] PSC_DIV256 = 10'h0ff;
  localparam logic [9:0] PSC_DIV1024 = 10'h3ff;

  // Crystal edges before a latched write lands, and processor cycles of flag synchronisation.
  localparam logic [1:0] XFER_EDGES = 2'h2;
  localparam int FLAG_SYNC_STAGES = 3;

  // AXI4-Lite responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } dspt_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } dspt_axi_rsp_t;

  typedef struct packed {
    logic [1:0]       xsync;
    logic             xprev;
    logic [7:0]       ctrl;
    logic [7:0]       cnt;
    logic [7:0]       ocr_buf;
    logic [7:0]       ocr_act;
    logic             dir_down;
    logic             pin;
    logic             async_sel;
    logic [9:0]       presc;
    logic [2:0][7:0]  tmp;
    logic [2:0]       busy;
    logic [2:0][1:0]  edges;
    logic [7:0]       shadow;
    logic             ovf_flag;
    logic             cmp_flag;
    logic             ovf_en;
    logic             cmp_en;
    logic [1:0]       ev_pend;
    logic [FLAG_SYNC_STAGES-1:0][1:0] fsync;
    logic             rearm;
    logic             aw_held;
    logic [31:0]      awaddr_h;
    logic             w_held;
    logic [7:0]       wdata_h;
    logic             wstrb_h;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [7:0]       rdata;
    logic [1:0]       rresp;
  } dspt_state_t;

  localparam dspt_state_t STATE_RESET = '0;

endpackage

// *** hw/dspt_timer.sv ***
// Dual-slope PWM timer slice with asynchronous crystal clocking behind an AXI4-Lite slave.
// Summary of operation
// - Mode code 1 counts up then down.
// - Mode 2: clear on up match, set down.
// - Mode 3: set on up match, clear down.
// - Fixed eight-bit resolution, turning at 0xFF.
// - Counter holds maximum one tick, then decrements.
// - Overflow flag set when counter reaches zero.
// - Compare zero low, maximum high; inverted opposite.
// - At maximum, output takes up-match level unless compare is 0xFF.
// - Missed up match still gives symmetric transition.
// - Period is 510 prescaled ticks.
// - Async control, count and compare writes land after two crystal edges.
// - Separate busy flag per latched register.
// - Pending compare or count write suppresses matching.
// - Interrupt re-arms after one crystal cycle.
// - Async interrupt follows on next timer cycle.
// - Async count reads via crystal-refreshed shadow register.
// - Async flag sync: three cycles plus one.
// - Output pin changes on timer tick only.
// - Async select runs timer from crystal input.
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
module dspt_timer (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Register bus
  input  wire dspt_pkg::dspt_axi_req_t axi_req,
  output dspt_pkg::dspt_axi_rsp_t axi_rsp,
  // Crystal clock, sampled as an ordinary input
  input  wire logic crystal_clock_input,
  // Waveform output and interrupt request
  output logic compare_output_pin,
  output logic compare_output_en,
  output logic irq_request
);

  dspt_pkg::dspt_state_t st_r;
  dspt_pkg::dspt_state_t st_nxt;

  function automatic logic addr_ok(input logic [31:0] a);
    addr_ok = (a == dspt_pkg::OFS_CONTROL) || (a == dspt_pkg::OFS_COUNT) ||
              (a == dspt_pkg::OFS_COMPARE) || (a == dspt_pkg::OFS_STATUS) ||
              (a == dspt_pkg::OFS_FLAGS) || (a == dspt_pkg::OFS_ENABLE);
  endfunction

  always_comb begin
    logic xedge;
    logic src_edge;
    logic tick;
    logic [9:0] mask;
    logic [1:0] wgm;
    logic [1:0] com;
    logic cmp_ok;
    logic match;
    logic ev_ovf;
    logic ev_cmp;
    logic set_ovf;
    logic set_cmp;
    logic [7:0] new_ocr;
    logic aw_have;
    logic w_have;
    logic [31:0] wa;
    logic [7:0] wd;
    logic we;
    logic clr_any;
    st_nxt = st_r;
    xedge = 1'b0;
    src_edge = 1'b0;
    tick = 1'b0;
    mask = dspt_pkg::PSC_DIV1;
    wgm = {st_r.ctrl[dspt_pkg::CTL_WGM_HI], st_r.ctrl[dspt_pkg::CTL_WGM_LO]};
    com = st_r.ctrl[dspt_pkg::CTL_COM_HI:dspt_pkg::CTL_COM_LO];
    cmp_ok = 1'b0;
    match = 1'b0;
    ev_ovf = 1'b0;
    ev_cmp = 1'b0;
    set_ovf = 1'b0;
    set_cmp = 1'b0;
    new_ocr = st_r.ocr_buf;
    aw_have = 1'b0;
    w_have = 1'b0;
    wa = st_r.awaddr_h;
    wd = st_r.wdata_h;
    we = st_r.wstrb_h;
    clr_any = 1'b0;

    // The first synchroniser stage feeds only the second; edges are found past it.
    st_nxt.xsync = {st_r.xsync[0], crystal_clock_input};
    st_nxt.xprev = st_r.xsync[1];
    xedge = st_r.xsync[1] & ~st_r.xprev;

    // Timer clock source and prescaler.
    src_edge = st_r.async_sel ? xedge : 1'b1;
    if (src_edge) begin
      st_nxt.presc = st_r.presc + 10'h001;
    end
    case (st_r.ctrl[2:0])
      3'h1: mask = dspt_pkg::PSC_DIV1;
      3'h2: mask = dspt_pkg::PSC_DIV8;
      3'h3: mask = dspt_pkg::PSC_DIV32;
      3'h4: mask = dspt_pkg::PSC_DIV64;
      3'h5: mask = dspt_pkg::PSC_DIV128;
      3'h6: mask = dspt_pkg::PSC_DIV256;
      3'h7: mask = dspt_pkg::PSC_DIV1024;
      default: mask = dspt_pkg::PSC_DIV1;
    endcase
    tick = src_edge && (st_r.ctrl[2:0] != 3'h0) && ((st_r.presc & mask) == mask);

    // A pending count or compare write blocks matching.
    cmp_ok = ~(st_r.busy[dspt_pkg::BUSY_COUNT] | st_r.busy[dspt_pkg::BUSY_COMPARE]);
    match = cmp_ok && (st_r.cnt == st_r.ocr_act);

    if (tick) begin
      ev_cmp = match;
      if (wgm == dspt_pkg::MODE_DUAL_SLOPE) begin
        if (!st_r.dir_down && st_r.cnt == dspt_pkg::CNT_MAX) begin
          // Turnaround: one tick at maximum, new compare value taken here.
          st_nxt.cnt = dspt_pkg::CNT_MAX - dspt_pkg::CNT_ONE;
          st_nxt.dir_down = 1'b1;
          st_nxt.ocr_act = new_ocr;
          // Compare at maximum behaves as a down match, otherwise the up level keeps symmetry.
          if (com[1]) begin
            st_nxt.pin = (new_ocr == dspt_pkg::CNT_MAX) ? ~com[0] : com[0];
          end
        end else begin
          if (st_r.dir_down && st_r.cnt == dspt_pkg::CNT_BOTTOM) begin
            st_nxt.cnt = dspt_pkg::CNT_ONE;
            st_nxt.dir_down = 1'b0;
          end else if (st_r.dir_down) begin
            st_nxt.cnt = st_r.cnt - dspt_pkg::CNT_ONE;
            ev_ovf = (st_r.cnt == dspt_pkg::CNT_ONE);
          end else begin
            st_nxt.cnt = st_r.cnt + dspt_pkg::CNT_ONE;
          end
          // A match at bottom counts as an up match so a zero compare stays low in mode 2 and high in mode 3.
          if (match && com[1]) begin
            if (st_r.dir_down && st_r.cnt != dspt_pkg::CNT_BOTTOM) begin
              st_nxt.pin = ~com[0];
            end else begin
              st_nxt.pin = com[0];
            end
          end
        end
      end else begin
        // Other modes simply count up and wrap with an unbuffered compare.
        st_nxt.cnt = st_r.cnt + dspt_pkg::CNT_ONE;
        st_nxt.dir_down = 1'b0;
        st_nxt.ocr_act = st_r.ocr_buf;
        ev_ovf = (st_r.cnt == dspt_pkg::CNT_MAX);
      end
    end
    if (wgm != dspt_pkg::MODE_DUAL_SLOPE) begin
      st_nxt.ocr_act = st_r.ocr_buf;
    end

    // Flag path: direct in synchronous mode, delayed one crystal cycle plus three stages otherwise.
    st_nxt.fsync = {st_r.fsync[dspt_pkg::FLAG_SYNC_STAGES-2:0], 2'h0};
    if (st_r.async_sel) begin
      st_nxt.ev_pend = st_r.ev_pend | {ev_cmp, ev_ovf};
      if (xedge) begin
        st_nxt.fsync[0] = st_r.ev_pend;
        st_nxt.ev_pend = {ev_cmp, ev_ovf};
      end
      set_ovf = st_r.fsync[dspt_pkg::FLAG_SYNC_STAGES-1][0];
      set_cmp = st_r.fsync[dspt_pkg::FLAG_SYNC_STAGES-1][1];
    end else begin
      st_nxt.ev_pend = 2'h0;
      set_ovf = ev_ovf;
      set_cmp = ev_cmp;
    end

    // Shadow of the count refreshed on every crystal edge.
    if (xedge) begin
      st_nxt.shadow = st_r.cnt;
      st_nxt.rearm = 1'b1;
    end

    // Latched writes land on the second crystal edge after they were made.
    for (int i = 0; i < 3; i++) begin
      if (st_r.busy[i] && xedge) begin
        st_nxt.edges[i] = st_r.edges[i] + 2'h1;
        if (st_r.edges[i] + 2'h1 == dspt_pkg::XFER_EDGES) begin
          st_nxt.busy[i] = 1'b0;
          st_nxt.edges[i] = 2'h0;
          case (i)
            dspt_pkg::BUSY_COUNT: st_nxt.cnt = st_r.tmp[i];
            dspt_pkg::BUSY_COMPARE: st_nxt.ocr_buf = st_r.tmp[i];
            default: st_nxt.ctrl = st_r.tmp[i];
          endcase
        end
      end
    end

    // Write channel: address and data are taken independently, in either order.
    aw_have = st_r.aw_held | (axi_req.awvalid & ~st_r.bvalid);
    w_have = st_r.w_held | (axi_req.wvalid & ~st_r.bvalid);
    if (!st_r.aw_held) begin
      wa = axi_req.awaddr;
    end
    if (!st_r.w_held) begin
      wd = axi_req.wdata[7:0];
      we = axi_req.wstrb[0];
    end
    st_nxt.aw_held = aw_have & ~w_have;
    st_nxt.w_held = w_have & ~aw_have;
    if (!st_r.aw_held) begin
      st_nxt.awaddr_h = axi_req.awaddr;
    end
    if (!st_r.w_held) begin
      st_nxt.wdata_h = axi_req.wdata[7:0];
      st_nxt.wstrb_h = axi_req.wstrb[0];
    end
    if (st_r.bvalid && axi_req.bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (aw_have && w_have) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = addr_ok(wa) ? dspt_pkg::RESP_OKAY : dspt_pkg::RESP_SLVERR;
      if (we) begin
        case (wa)
          dspt_pkg::OFS_CONTROL: begin
            if (st_r.async_sel) begin
              st_nxt.tmp[dspt_pkg::BUSY_CONTROL] = wd & dspt_pkg::CTL_WRITE_MASK;
              st_nxt.busy[dspt_pkg::BUSY_CONTROL] = 1'b1;
              st_nxt.edges[dspt_pkg::BUSY_CONTROL] = 2'h0;
            end else begin
              st_nxt.ctrl = wd & dspt_pkg::CTL_WRITE_MASK;
            end
          end
          dspt_pkg::OFS_COUNT: begin
            if (st_r.async_sel) begin
              st_nxt.tmp[dspt_pkg::BUSY_COUNT] = wd;
              st_nxt.busy[dspt_pkg::BUSY_COUNT] = 1'b1;
              st_nxt.edges[dspt_pkg::BUSY_COUNT] = 2'h0;
            end else begin
              st_nxt.cnt = wd;
            end
          end
          dspt_pkg::OFS_COMPARE: begin
            if (st_r.async_sel) begin
              st_nxt.tmp[dspt_pkg::BUSY_COMPARE] = wd;
              st_nxt.busy[dspt_pkg::BUSY_COMPARE] = 1'b1;
              st_nxt.edges[dspt_pkg::BUSY_COMPARE] = 2'h0;
            end else begin
              st_nxt.ocr_buf = wd;
            end
          end
          dspt_pkg::OFS_STATUS: st_nxt.async_sel = wd[dspt_pkg::STS_ASYNC];
          dspt_pkg::OFS_FLAGS: begin
            clr_any = wd[dspt_pkg::FLG_OVERFLOW] | wd[dspt_pkg::FLG_COMPARE];
            if (wd[dspt_pkg::FLG_OVERFLOW]) begin
              st_nxt.ovf_flag = 1'b0;
            end
            if (wd[dspt_pkg::FLG_COMPARE]) begin
              st_nxt.cmp_flag = 1'b0;
            end
          end
          dspt_pkg::OFS_ENABLE: begin
            st_nxt.ovf_en = wd[dspt_pkg::FLG_OVERFLOW];
            st_nxt.cmp_en = wd[dspt_pkg::FLG_COMPARE];
          end
          default: st_nxt.bresp = dspt_pkg::RESP_SLVERR;
        endcase
      end
    end
    // Clearing a flag in asynchronous mode disarms the request until the next crystal edge.
    if (clr_any && st_r.async_sel && !xedge) begin
      st_nxt.rearm = 1'b0;
    end
    // A hardware set in the clearing cycle wins.
    if (set_ovf) begin
      st_nxt.ovf_flag = 1'b1;
    end
    if (set_cmp) begin
      st_nxt.cmp_flag = 1'b1;
    end

    // Read channel.
    if (st_r.rvalid && axi_req.rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = dspt_pkg::RESP_OKAY;
      case (axi_req.araddr)
        dspt_pkg::OFS_CONTROL: st_nxt.rdata = st_r.ctrl;
        dspt_pkg::OFS_COUNT: st_nxt.rdata = st_r.async_sel ? st_r.shadow : st_r.cnt;
        dspt_pkg::OFS_COMPARE: st_nxt.rdata = st_r.ocr_buf;
        dspt_pkg::OFS_STATUS: st_nxt.rdata = {4'h0, st_r.async_sel, st_r.busy};
        dspt_pkg::OFS_FLAGS: st_nxt.rdata = {6'h00, st_r.cmp_flag, st_r.ovf_flag};
        dspt_pkg::OFS_ENABLE: st_nxt.rdata = {6'h00, st_r.cmp_en, st_r.ovf_en};
        default: begin
          st_nxt.rdata = 8'h00;
          st_nxt.rresp = dspt_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= dspt_pkg::STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    axi_rsp.awready = ~st_r.aw_held & ~st_r.bvalid;
    axi_rsp.wready = ~st_r.w_held & ~st_r.bvalid;
    axi_rsp.bvalid = st_r.bvalid;
    axi_rsp.bresp = st_r.bresp;
    axi_rsp.arready = ~st_r.rvalid;
    axi_rsp.rvalid = st_r.rvalid;
    axi_rsp.rdata = {24'h000000, st_r.rdata};
    axi_rsp.rresp = st_r.rresp;
  end

  assign compare_output_pin = st_r.pin;
  assign compare_output_en = st_r.ctrl[dspt_pkg::CTL_COM_HI];
  assign irq_request = st_r.rearm & ((st_r.ovf_flag & st_r.ovf_en) | (st_r.cmp_flag & st_r.cmp_en));

endmodule

// *** tb/dspt_crystal_model.sv ***
// Free-running crystal source that clocks the timer in asynchronous mode.
`timescale 1ns/100ps
module dspt_crystal_model #(
  parameter int HALF_NS = 40
) (
  // Crystal output
  output logic crystal_clock_input
);
  // A watch crystal never stops, and the start offset keeps its edges clear of aclk edges.
  initial begin
    crystal_clock_input = 1'b0;
    #3;
    forever #(HALF_NS) crystal_clock_input = ~crystal_clock_input;
  end
endmodule

// *** tb/dspt_timer_assertions.sv ***
// Bus handshake checks on the ports of the dual-slope PWM timer.
`timescale 1ns/100ps
module dspt_timer_assertions (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire dspt_pkg::dspt_axi_req_t axi_req,
  input wire dspt_pkg::dspt_axi_rsp_t axi_rsp,
  // Timer pins
  input wire logic crystal_clock_input,
  input wire logic compare_output_pin,
  input wire logic compare_output_en,
  input wire logic irq_request
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence s_rd_taken;
    axi_req.arvalid && axi_rsp.arready;
  endsequence
  AST_WR_ANSWER: assert property (s_wr_taken |=> axi_rsp.bvalid) else $error("write not answered");
  AST_B_HOLD: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped");
  AST_B_BLOCK: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write accepted while answering");
  AST_B_DROP: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid) else $error("bvalid stuck");
  AST_RD_ANSWER: assert property (s_rd_taken |-> ##1 axi_rsp.rvalid) else $error("read not answered");
  AST_R_HOLD: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data changed");
  AST_R_BLOCK: assert property (axi_rsp.rvalid |-> !axi_rsp.arready) else $error("read accepted while answering");
  AST_R_UPPER: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h0) else $error("upper read bits set");
  AST_RD_UNMAPPED: assert property (s_rd_taken and axi_req.araddr >= 32'h18 |=>
    axi_rsp.rresp == dspt_pkg::RESP_SLVERR && axi_rsp.rdata == 32'h0) else $error("unmapped read not refused");
  cover property ($rose(compare_output_pin) && compare_output_en);
  cover property ($rose(irq_request));
  cover property ($rose(crystal_clock_input));
endmodule
bind dspt_timer dspt_timer_assertions chk (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .crystal_clock_input(crystal_clock_input), .compare_output_pin(compare_output_pin),
  .compare_output_en(compare_output_en), .irq_request(irq_request));

// *** tb/tb_dual_slope_pwm_async_timer.sv ***
// Self-checking testbench for the dual-slope PWM timer.
`timescale 1ns/100ps
`define CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) begin errors++; $display("CHECK FAILED %0t %s", $time, m); end end
module tb_dual_slope_pwm_async_timer;
  localparam int XP = 16;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  dspt_pkg::dspt_axi_req_t req = '0;
  dspt_pkg::dspt_axi_rsp_t rsp;
  logic xtal;
  logic pin;
  logic pin_en;
  logic irq;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic [1:0] rs;

  always #2.5 aclk = ~aclk;

  dspt_crystal_model #(.HALF_NS(40)) xm (.crystal_clock_input(xtal));

  dspt_timer uut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .crystal_clock_input(xtal),
    .compare_output_pin(pin), .compare_output_en(pin_en), .irq_request(irq));

  task automatic conclude;
    if (errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      conclude();
    end
  end

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        rs = rsp.bresp;
        req.bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rdr(input logic [31:0] a);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        rd = rsp.rdata;
        rs = rsp.rresp;
        req.rready <= 1'b0;
        break;
      end
    end
  endtask

  // Software must not rewrite a register whose latched write is still pending.
  task automatic wait_idle;
    do rdr(dspt_pkg::OFS_STATUS); while (rd[2:0] !== 3'h0);
  endtask

  task automatic t_regs;
    logic [31:0] ofs [4] = '{dspt_pkg::OFS_CONTROL, dspt_pkg::OFS_STATUS, dspt_pkg::OFS_FLAGS, dspt_pkg::OFS_ENABLE};
    foreach (ofs[i]) begin
      rdr(ofs[i]);
      `CHK(rd, 32'h0, "reset value")
    end
    wr(dspt_pkg::OFS_CONTROL, 32'hff);
    rdr(dspt_pkg::OFS_CONTROL);
    `CHK(rd, 32'h7f, "control readback")
    wr(32'h20, 32'h1);
    `CHK(rs, dspt_pkg::RESP_SLVERR, "unmapped write")
    rdr(32'h20);
    `CHK({rs, rd}, {dspt_pkg::RESP_SLVERR, 32'h0}, "unmapped read")
    wr(dspt_pkg::OFS_CONTROL, 32'h0);
  endtask

  task automatic t_period;
    logic [7:0] c0;
    int t0;
    int dv;
    for (int cs = 1; cs < 3; cs++) begin
      dv = (cs == 1) ? 1 : 8;
      wr(dspt_pkg::OFS_CONTROL, {24'h0, 5'h08, 3'(cs)});
      repeat (20) @(posedge aclk);
      t0 = cyc;
      rdr(dspt_pkg::OFS_COUNT);
      c0 = rd[7:0];
      while (cyc < t0 + 255 * dv) @(posedge aclk);
      rdr(dspt_pkg::OFS_COUNT);
      `CHK(8'(c0 + rd[7:0]), 8'hff, "half period mirror")
      while (cyc < t0 + 510 * dv) @(posedge aclk);
      rdr(dspt_pkg::OFS_COUNT);
      `CHK(rd[7:0], c0, "full period")
    end
  endtask

  // Starting at compare 0xff makes the next case leave the maximum, the awkward edge for symmetry.
  task automatic t_pwm;
    logic [7:0] oc [3] = '{8'hff, 8'h40, 8'h00};
    int hi;
    for (int c = 2; c < 4; c++) begin
      foreach (oc[i]) begin
        wr(dspt_pkg::OFS_CONTROL, {24'h0, 2'h1, 2'(c), 4'h1});
        wr(dspt_pkg::OFS_COMPARE, {24'h0, oc[i]});
        repeat (1100) @(posedge aclk);
        hi = 0;
        repeat (510) begin
          @(posedge aclk);
          hi += int'(pin);
        end
        `CHK(hi, (c == 2) ? 2 * oc[i] : 510 - 2 * oc[i], "pwm high time")
        `CHK(pin_en, 1'b1, "output enable")
      end
    end
  endtask

  task automatic t_irq;
    wr(dspt_pkg::OFS_CONTROL, 32'h41);
    wr(dspt_pkg::OFS_FLAGS, 32'h3);
    wr(dspt_pkg::OFS_ENABLE, 32'h1);
    repeat (520) @(posedge aclk);
    rdr(dspt_pkg::OFS_FLAGS);
    `CHK(rd[0], 1'b1, "overflow flag")
    `CHK(irq, 1'b1, "irq raised")
    wr(dspt_pkg::OFS_ENABLE, 32'h0);
    `CHK(irq, 1'b0, "irq masked")
    wr(dspt_pkg::OFS_CONTROL, 32'h40);
    wr(dspt_pkg::OFS_FLAGS, 32'h3);
    wr(dspt_pkg::OFS_ENABLE, 32'h3);
    rdr(dspt_pkg::OFS_FLAGS);
    `CHK({irq, rd[1:0]}, 3'h0, "flags cleared")
  endtask

  task automatic t_async;
    int t0;
    logic [7:0] c0;
    wr(dspt_pkg::OFS_ENABLE, 32'h0);
    wr(dspt_pkg::OFS_STATUS, 32'h8);
    // Plain up counting keeps the count direction known for the rate checks below.
    wr(dspt_pkg::OFS_CONTROL, 32'h01);
    rdr(dspt_pkg::OFS_STATUS);
    `CHK(rd[3:0], 4'h9, "control busy")
    wait_idle();
    wr(dspt_pkg::OFS_COMPARE, 32'h55);
    t0 = cyc;
    rdr(dspt_pkg::OFS_STATUS);
    `CHK(rd[3:0], 4'ha, "compare busy")
    wait_idle();
    `CHK(cyc - t0 >= XP - 4 && cyc - t0 <= 3 * XP, 1'b1, "latched write delay")
    wr(dspt_pkg::OFS_COUNT, 32'h10);
    rdr(dspt_pkg::OFS_STATUS);
    `CHK(rd[3:0], 4'hc, "count busy")
    wait_idle();
    // The shadow keeps the old count until the crystal edge after the landing.
    repeat (XP) @(posedge aclk);
    rdr(dspt_pkg::OFS_COUNT);
    c0 = rd[7:0];
    `CHK(c0, 8'h10, "count landed")
    // Reads exactly eight crystal periods apart span exactly eight shadow refreshes.
    repeat (8 * XP - 3) @(posedge aclk);
    rdr(dspt_pkg::OFS_COUNT);
    `CHK(8'(rd[7:0] - c0), 8'h08, "crystal rate")
    wr(dspt_pkg::OFS_COUNT, 32'hfd);
    wait_idle();
    wr(dspt_pkg::OFS_FLAGS, 32'h3);
    // The wrap comes three crystal periods after landing; the flag follows a crystal period and three cycles later.
    repeat (50) @(posedge aclk);
    rdr(dspt_pkg::OFS_FLAGS);
    `CHK(rd[0], 1'b0, "overflow not yet synchronised")
    repeat (12) @(posedge aclk);
    rdr(dspt_pkg::OFS_FLAGS);
    `CHK(rd[0], 1'b1, "overflow synchronised")
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_period();
    t_pwm();
    t_irq();
    t_async();
    conclude();
  end
endmodule
